/* logic/lecm_params.svh */
// Purpose: constants for the lane error counter monitor
// Assumes: byte wide registers on a 12-bit register address space
// Notes:   definitions only
`ifndef LECM_PARAMS_SVH
`define LECM_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define LECM_ADDR_W        12
`define LECM_DATA_W        8
`define LECM_ADDR_SUM      12'h045D
`define LECM_ADDR_MON      12'h046B
`define LECM_ADDR_DIS      12'h046D

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LECM_LANE_MSB      6
`define LECM_LANE_LSB      4
`define LECM_KIND_MSB      1
`define LECM_KIND_LSB      0
`define LECM_DIS_CLR_BIT   5
`define LECM_DIS_LANE_MSB  2
`define LECM_SUM_RST       8'h45
`define LECM_RDATA_RST     8'h00

`endif

/* logic/lecm_pkg.sv */
// Purpose: shared types of the lane error counter monitor
// Assumes: lecm_params.svh supplies the widths
// Notes:   no imports; users write lecm_pkg::name
`include "lecm_params.svh"

package lecm_pkg;

  // ----------------------------------------------------------------
  // counter kinds as chosen by the counter selector
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LECM_KIND_DISP  = 2'b00,
    LECM_KIND_TABLE = 2'b01,
    LECM_KIND_CTRL  = 2'b10,
    LECM_KIND_NONE  = 2'b11
  } lecm_kind_t;

  // ----------------------------------------------------------------
  // one register access request
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic                      wr;
    logic                      rd;
    logic [`LECM_ADDR_W-1:0]   addr;
    logic [`LECM_DATA_W-1:0]   wdata;
  } lecm_req_t;

endpackage : lecm_pkg

/* logic/lecm_top.sv */
// Purpose: checksum byte and indirect per-lane error counter readback
// Assumes: register port and lane error strobes on CORE_CLK_I
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "lecm_params.svh"

module lecm_top
#(
  parameter int LANES = 8,
  parameter int CNT_W = 8
)
(
  // clock and reset
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_I,
  // register port
  input  wire lecm_pkg::lecm_req_t      REG_REQ_I,
  output logic [`LECM_DATA_W-1:0]       REG_RDATA_O,
  output logic                          REG_RVALID_O,
  // per-lane error strobes from the lane decoders
  input  wire logic [LANES-1:0]         DISP_ERR_I,
  input  wire logic [LANES-1:0]         TABLE_ERR_I,
  input  wire logic [LANES-1:0]         CTRL_ERR_I,
  // checksum byte for the link parameter checker
  output logic [`LECM_DATA_W-1:0]       LANE_ZERO_PARAM_SUM_O
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LANES < 1 || LANES > 8)
  begin : g_bad_lanes
    $error("LANES must be 1 to 8");
  end
  if (CNT_W != `LECM_DATA_W)
  begin : g_bad_cnt
    $error("CNT_W must equal the register width");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [`LECM_DATA_W-1:0]  lane_zero_param_sum_r;
  logic [2:0]               lane_pick_r;
  lecm_pkg::lecm_kind_t     counter_pick_r;
  logic [CNT_W-1:0]         cnt_r [3][LANES];
  logic [LANES-1:0]         err_ev [3];
  logic                     wr_sum;
  logic                     wr_mon;
  logic                     wr_dis;
  logic                     rd_any;
  logic                     dis_clr;
  logic [2:0]               dis_lane;
  logic [`LECM_DATA_W-1:0]  counter_readback;
  logic [`LECM_DATA_W-1:0]  rdata_nxt;

  // saturating increment shared by all counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 1'b1;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wr_sum   = REG_REQ_I.wr && (REG_REQ_I.addr == `LECM_ADDR_SUM);
  assign wr_mon   = REG_REQ_I.wr && (REG_REQ_I.addr == `LECM_ADDR_MON);
  assign wr_dis   = REG_REQ_I.wr && (REG_REQ_I.addr == `LECM_ADDR_DIS);
  assign rd_any   = REG_REQ_I.rd;
  assign dis_clr  = wr_dis && REG_REQ_I.wdata[`LECM_DIS_CLR_BIT];
  assign dis_lane = REG_REQ_I.wdata[`LECM_DIS_LANE_MSB:0];
  assign err_ev[0] = DISP_ERR_I;
  assign err_ev[1] = TABLE_ERR_I;
  assign err_ev[2] = CTRL_ERR_I;

  // ----------------------------------------------------------------
  // checksum byte
  // ----------------------------------------------------------------
  // checksum storage
  // the device only stores it; software computes the sum
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      lane_zero_param_sum_r <= `LECM_SUM_RST;
    else if (wr_sum)
      lane_zero_param_sum_r <= REG_REQ_I.wdata;
  end

  assign LANE_ZERO_PARAM_SUM_O = lane_zero_param_sum_r;

  // ----------------------------------------------------------------
  // selectors, write only
  // ----------------------------------------------------------------
  // selector capture
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      lane_pick_r    <= 3'h0;
      counter_pick_r <= lecm_pkg::LECM_KIND_DISP;
    end
    else if (wr_mon)
    begin
      lane_pick_r    <= REG_REQ_I.wdata[`LECM_LANE_MSB:`LECM_LANE_LSB];
      counter_pick_r <= lecm_pkg::lecm_kind_t'(REG_REQ_I.wdata[`LECM_KIND_MSB:`LECM_KIND_LSB]);
    end
  end

  // ----------------------------------------------------------------
  // per-lane error counters
  // ----------------------------------------------------------------
  // counting with saturation
  // clear then count in the same cycle, so an error never gets lost
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      for (int k = 0; k < 3; k++)
        for (int l = 0; l < LANES; l++)
          cnt_r[k][l] <= '0;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
        for (int l = 0; l < LANES; l++)
        begin
          if (k == 0 && dis_clr && dis_lane == 3'(l))
            cnt_r[k][l] <= err_ev[k][l] ? CNT_W'(1) : '0;
          else if (err_ev[k][l])
            cnt_r[k][l] <= sat_inc(cnt_r[k][l]);
        end
    end
  end

  // ----------------------------------------------------------------
  // indirect readback
  // ----------------------------------------------------------------
  // kind decode and counter mux
  // lanes beyond LANES and the unused kind read as zero
  always_comb
  begin
    counter_readback = '0;
    if (int'(lane_pick_r) < LANES)
    begin
      unique case (counter_pick_r)
        lecm_pkg::LECM_KIND_DISP  : counter_readback = cnt_r[0][lane_pick_r];
        lecm_pkg::LECM_KIND_TABLE : counter_readback = cnt_r[1][lane_pick_r];
        lecm_pkg::LECM_KIND_CTRL  : counter_readback = cnt_r[2][lane_pick_r];
        lecm_pkg::LECM_KIND_NONE  : counter_readback = '0;
      endcase
    end
  end

  // read data mux; unmapped addresses answer zero
  always_comb
  begin
    rdata_nxt = `LECM_RDATA_RST;
    if (REG_REQ_I.addr == `LECM_ADDR_SUM)
      rdata_nxt = lane_zero_param_sum_r;
    else if (REG_REQ_I.addr == `LECM_ADDR_MON)
      rdata_nxt = counter_readback;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      REG_RDATA_O  <= `LECM_RDATA_RST;
      REG_RVALID_O <= 1'b0;
    end
    else
    begin
      REG_RVALID_O <= rd_any;
      if (rd_any)
        REG_RDATA_O <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_mon_read;
    REG_REQ_I.rd && !REG_REQ_I.wr && REG_REQ_I.addr == `LECM_ADDR_MON;
  endsequence

  sequence s_sel_write;
    wr_mon && !REG_REQ_I.rd;
  endsequence

  chk_sum_store: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_sum |=> lane_zero_param_sum_r == $past(REG_REQ_I.wdata))
    else $error("checksum byte not stored");

  chk_sum_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (REG_REQ_I.rd && REG_REQ_I.addr == `LECM_ADDR_SUM) |=>
    REG_RVALID_O && REG_RDATA_O == $past(lane_zero_param_sum_r))
    else $error("checksum readback wrong");

  chk_lane_pick: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_mon |=> lane_pick_r == $past(REG_REQ_I.wdata[6:4]))
    else $error("lane selector not captured");

  chk_kind_pick: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_mon |=> counter_pick_r == $past(REG_REQ_I.wdata[1:0]))
    else $error("counter selector not captured");

  chk_sel_then_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (s_sel_write ##1 s_mon_read) |=> REG_RVALID_O &&
    REG_RDATA_O == $past(counter_readback))
    else $error("read after select not served");

  chk_disp_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (s_mon_read and (counter_pick_r == lecm_pkg::LECM_KIND_DISP) and
    (lane_pick_r == 3'h0)) |=> REG_RDATA_O == $past(cnt_r[0][0]))
    else $error("disparity count not returned");

  chk_table_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (s_mon_read and (counter_pick_r == lecm_pkg::LECM_KIND_TABLE) and
    (lane_pick_r == 3'h0)) |=> REG_RDATA_O == $past(cnt_r[1][0]))
    else $error("table miss count not returned");

  chk_ctrl_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (s_mon_read and (counter_pick_r == lecm_pkg::LECM_KIND_CTRL) and
    (lane_pick_r == 3'h0)) |=> REG_RDATA_O == $past(cnt_r[2][0]))
    else $error("control char count not returned");

  chk_count_inc: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (TABLE_ERR_I[0] && cnt_r[1][0] != CNT_MAX) |=> cnt_r[1][0] == $past(cnt_r[1][0]) + 1'b1)
    else $error("counter did not add one");

  // watch the top lane, the one that is driven into saturation and then cleared
  chk_count_sat: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (cnt_r[0][LANES-1] == CNT_MAX && !(dis_clr && dis_lane == 3'(LANES-1))) |=>
    cnt_r[0][LANES-1] == CNT_MAX)
    else $error("counter wrapped");

  chk_disp_clear: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (dis_clr && dis_lane == 3'(LANES-1) && !DISP_ERR_I[LANES-1]) |=>
    cnt_r[0][LANES-1] == '0)
    else $error("disparity clear failed");

endmodule : lecm_top

/* tb/lecm_lane_src.sv */
// Purpose: lane error source standing in for the lane decoders
// Assumes: strobes ride the core clock, one error per high cycle
// Notes:   strobes idle low between bursts; kind three drives nothing
`timescale 1ns/100ps
module lecm_lane_src
(
  // clock
  input  wire logic        clk_i,
  // burst command from the bench
  input  wire logic        go_i,
  input  wire logic [2:0]  lane_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic [15:0] num_i,
  // error strobes and status
  output logic [7:0]       disp_o,
  output logic [7:0]       table_o,
  output logic [7:0]       ctrl_o,
  output logic             busy_o
);
  logic [15:0] left_r = 16'h0000;
  logic [7:0]  hot;

  // burst length counts down, one error a cycle
  always_ff @(posedge clk_i)
    left_r <= go_i ? num_i : ((left_r != 16'h0000) ? left_r - 16'h0001 : left_r);

  assign hot     = (left_r != 16'h0000) ? (8'h01 << lane_i) : 8'h00;
  assign disp_o  = (kind_i == 2'h0) ? hot : 8'h00;
  assign table_o = (kind_i == 2'h1) ? hot : 8'h00;
  assign ctrl_o  = (kind_i == 2'h2) ? hot : 8'h00;
  assign busy_o  = go_i | (left_r != 16'h0000);
endmodule : lecm_lane_src

/* tb/tb_top.sv */
// Purpose: self-checking bench for the lane error counter monitor
// Assumes: registered read answer one cycle after the read strobe
// Notes:   expectations come from burst lengths set here
`timescale 1ns/100ps
`include "lecm_params.svh"
module tb_top;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  lecm_pkg::lecm_req_t req = '0;
  logic [7:0]          rdata;
  logic [7:0]          psum;
  logic                rvalid;
  logic [7:0]          de;
  logic [7:0]          te;
  logic [7:0]          ce;
  logic                go = 1'b0;
  logic                busy;
  logic [2:0]          glane = 3'h0;
  logic [1:0]          gkind = 2'h0;
  logic [15:0]         gnum = 16'h0000;
  int                  miscompares = 0;
  int                  compares = 0;

  // 100 MHz core clock
  always #5 clk = ~clk;

  lecm_top #(.LANES(8), .CNT_W(8)) DUT (.CORE_CLK_I(clk), .RST_I(rst), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .DISP_ERR_I(de), .TABLE_ERR_I(te),
    .CTRL_ERR_I(ce), .LANE_ZERO_PARAM_SUM_O(psum));
  lecm_lane_src SRC (.clk_i(clk), .go_i(go), .lane_i(glane), .kind_i(gkind), .num_i(gnum),
    .disp_o(de), .table_o(te), .ctrl_o(ce), .busy_o(busy));

  // ----------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : reg_wr

  // answer is registered, so look just after the taking edge
  task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    check("rvalid", 8'h01, {7'h00, rvalid});
    d = rdata;
  endtask : reg_rd

  task automatic burst(input logic [2:0] l, input logic [1:0] k, input logic [15:0] n);
    @(posedge clk);
    go <= 1'b1;
    glane <= l;
    gkind <= k;
    gnum <= n;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1) @(posedge clk) #1;
  endtask : burst

  task automatic rd_count(input logic [2:0] l, input logic [1:0] k, input logic [7:0] exp);
    logic [7:0] v;
    reg_wr(`LECM_ADDR_MON, {1'b0, l, 2'b00, k});
    reg_rd(`LECM_ADDR_MON, v);
    check("count", exp, v);
  endtask : rd_count

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_sum;
    logic [7:0] s;
    logic [7:0] v;
    check("sum reset", 8'h45, psum);
    s = 8'h00;
    for (int i = 0; i < 13; i++) s = s + 8'(i * 8'h1D + 8'h31);
    reg_wr(`LECM_ADDR_SUM, s);
    #1;
    check("sum out", s, psum);
    reg_rd(`LECM_ADDR_SUM, v);
    check("sum read", s, v);
    reg_wr(12'h0123, 8'h5A);
    reg_rd(12'h0123, v);
    check("unmapped", 8'h00, v);
    check("sum kept", s, psum);
  endtask : t_sum

  // every lane and kind gets its own burst length, so a mixup shows
  task automatic t_counts;
    for (int l = 0; l < 8; l++)
      for (int k = 0; k < 3; k++) burst(3'(l), 2'(k), 16'(l * 3 + k + 1));
    for (int l = 0; l < 8; l++)
    begin
      for (int k = 0; k < 3; k++) rd_count(3'(l), 2'(k), 8'(l * 3 + k + 1));
      rd_count(3'(l), 2'h3, 8'h00);
    end
  endtask : t_counts

  task automatic t_sat_clear;
    burst(3'h7, 2'h0, 16'h012C);
    rd_count(3'h7, 2'h0, 8'hFF);
    reg_wr(`LECM_ADDR_DIS, 8'h27);
    rd_count(3'h7, 2'h0, 8'h00);
    rd_count(3'h7, 2'h1, 8'h17);
    rd_count(3'h6, 2'h0, 8'h13);
    burst(3'h7, 2'h0, 16'h0002);
    rd_count(3'h7, 2'h0, 8'h02);
  endtask : t_sat_clear

  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // watchdog, well beyond the fewer than one thousand cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_count(3'h0, 2'h0, 8'h00);
    t_sum();
    t_counts();
    t_sat_clear();
    give_verdict();
  end
endmodule : tb_top
